// ===== sir_endec_common.sv
`timescale 1ns/10ps
`default_nettype none

package sir_endec_pkg;

	// rate table, indexed by rate_code
	localparam int RATE_COUNT = 13;
	localparam int RATE_TAB_SIZE = 16;
	localparam int unsigned RATE_BPS [RATE_COUNT] = '{
		115200, 57600, 38400, 19200, 14400, 12800, 9600,
		7200, 4800, 3600, 2400, 1800, 1200
	};
	localparam logic [3:0] RATE_CODE_MAX = 4'hc;

	// pulse shape
	localparam longint FIXED_PULSE_NS = 1627;
	localparam longint NS_PER_S = 1000000000;
	localparam longint SHORT_PULSE_NUM = 3;
	localparam longint SHORT_PULSE_DEN = 16;

	// control word layout, shared by the serial control character and the cfg register
	localparam int CFG_W = 8;
	localparam int CFG_RATE_LSB = 0;
	localparam int CFG_RATE_MSB = 3;
	localparam int CFG_PW_BIT = 4;
	localparam int CFG_OUT1_BIT = 5;
	localparam int CFG_OUT2_BIT = 6;
	// rate 9600, fixed pulse, echo suppression on, output two off
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h36;

	// register port
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CFG_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
	localparam int STAT_PROG_BIT = 0;
	localparam int STAT_TX_BIT = 1;
	localparam int STAT_RX_BIT = 2;
	localparam int STAT_PEND_BIT = 3;

	localparam int TIMER_W = 16;
	localparam int UART_DATA_BITS = 8;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;

	typedef enum logic [1:0] {
		PROG_IDLE = 2'b00,
		PROG_START = 2'b01,
		PROG_DATA = 2'b11,
		PROG_STOP = 2'b10
	} prog_state_type;

endpackage

////////////////////////////////////////////////////////////////////////////////

module pin_filter #(
	parameter logic INIT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and its clean level
	input wire logic pin,
	output logic level
);

	logic stage1;
	logic stage2;
	logic stage3;
	wire logic agree;

	// stage1 feeds stage2 only; a glitch must survive two samples
	assign agree = (stage2 == stage3);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			level <= INIT;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			if (agree) begin
				level <= stage3;
			end
		end
	end

endmodule // pin_filter

`default_nettype wire

// ===== sir_pulse_endec.sv
// What this block does
// - zero bits pulse, one bits stay dark
// - start bit zero, data LSB first
// - pulses on infrared transmit output, selectable width
// - three-sixteenths at 9600 gives 19.5 us
// - both widths equal at 115200
// - transmit lamp follows transmitted data
// - received pulse stretched to one bit period
// - output independent of received pulse width
// - receive lamp follows decoded data
// - rate defaults to 9600 after reset
// - receive input gated by transmit activity
// - output one switches echo suppression, default on
// - serial receive output clean while transmitting
// - select high: character is control word
// - control byte: rate, width, two outputs
// - width bit one fixed, zero three-sixteenths
// - thirteen rate codes, 115200 down to 1200
`timescale 1ns/10ps
`default_nettype none

module sir_pulse_endec
	import sir_endec_pkg::*;
#(
	parameter int CLK_HZ = 10000000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial port side
	input wire logic uart_serial_in,
	input wire logic rate_program_select,
	output logic uart_serial_out,
	// transceiver side
	output logic ir_tx_out,
	input wire logic ir_rx_in,
	// indicators and programmable outputs
	output logic tx_activity_lamp,
	output logic rx_activity_lamp,
	output logic user_output_one,
	output logic user_output_two,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [CFG_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [CFG_W-1:0] reg_rdata
);

	////////////////////////////////////////////////////////////////////////////
	// pin conditioning

	wire logic tx_line;
	wire logic prog_mode;
	wire logic rx_pin;

	// all three pins share one lag, so mode and line stay aligned
	pin_filter #(.INIT(1'b1)) tx_filter (
		.clk(clk),
		.rst_n(rst_n),
		.pin(uart_serial_in),
		.level(tx_line)
	);

	pin_filter #(.INIT(1'b0)) prog_filter (
		.clk(clk),
		.rst_n(rst_n),
		.pin(rate_program_select),
		.level(prog_mode)
	);

	pin_filter #(.INIT(1'b0)) rx_filter (
		.clk(clk),
		.rst_n(rst_n),
		.pin(ir_rx_in),
		.level(rx_pin)
	);

	////////////////////////////////////////////////////////////////////////////
	// configuration and timing tables

	logic [CFG_W-1:0] cfg;
	logic [CFG_W-1:0] pending;
	logic pending_valid;
	logic prog_prev;

	wire logic [3:0] rate_code;
	wire logic pulse_width_select;
	wire logic data_mode;
	wire logic prog_release;
	wire logic echo_suppress;

	assign rate_code = cfg[CFG_RATE_MSB:CFG_RATE_LSB];
	assign pulse_width_select = cfg[CFG_PW_BIT];
	assign data_mode = !prog_mode;
	assign prog_release = prog_prev && !prog_mode;
	assign echo_suppress = cfg[CFG_OUT1_BIT];

	logic [TIMER_W-1:0] bit_tab [RATE_TAB_SIZE];
	logic [TIMER_W-1:0] short_tab [RATE_TAB_SIZE];

	// rounded to nearest clock: 9600 gives 195 clocks (19.5 us) at 10 MHz
	for (genvar i = 0; i < RATE_TAB_SIZE; i++) begin : g_rate
		localparam longint BPS = longint'(RATE_BPS[(i < RATE_COUNT) ? i : RATE_COUNT - 1]);
		localparam longint HZ = longint'(CLK_HZ);
		assign bit_tab[i] = TIMER_W'((2 * HZ / BPS + 1) / 2);
		assign short_tab[i] = TIMER_W'(
			(2 * SHORT_PULSE_NUM * HZ / (SHORT_PULSE_DEN * BPS) + 1) / 2);
	end

	localparam longint FIXED_CYC_L =
		(2 * longint'(CLK_HZ) * FIXED_PULSE_NS / NS_PER_S + 1) / 2;
	localparam logic [TIMER_W-1:0] FIXED_CYC =
		TIMER_W'((FIXED_CYC_L < 1) ? 1 : FIXED_CYC_L);

	wire logic [TIMER_W-1:0] bit_cyc;
	wire logic [TIMER_W-1:0] pulse_cyc;
	wire logic [TIMER_W-1:0] half_cyc;
	wire logic [TIMER_W-1:0] bit_last;

	assign bit_cyc = bit_tab[rate_code];
	assign pulse_cyc = pulse_width_select ? FIXED_CYC : short_tab[rate_code];
	assign half_cyc = bit_cyc >> 1;
	assign bit_last = bit_cyc - TIMER_W'(1);

	////////////////////////////////////////////////////////////////////////////
	// transmit encoder

	logic tx_prev;
	logic [TIMER_W-1:0] tx_cnt;
	logic [TIMER_W-1:0] next_tx_cnt;
	wire logic tx_fall;
	wire logic tx_low;
	wire logic next_ir_tx;
	wire logic tx_busy;

	assign tx_fall = tx_prev && !tx_line;
	assign tx_low = data_mode && !tx_line;

	// a run of zeros restarts the bit clock at each bit boundary
	always_comb begin
		if (!tx_low) begin
			next_tx_cnt = bit_cyc;
		end else if (tx_fall) begin
			next_tx_cnt = '0;
		end else if (tx_cnt >= bit_last) begin
			next_tx_cnt = '0;
		end else begin
			next_tx_cnt = tx_cnt + TIMER_W'(1);
		end
	end

	// pulse_cyc stays below bit_cyc at every rate, so zeros never merge
	assign next_ir_tx = tx_low && (next_tx_cnt < pulse_cyc);
	assign tx_busy = tx_low || ir_tx_out;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_prev <= 1'b1;
			tx_cnt <= '0;
			ir_tx_out <= 1'b0;
			tx_activity_lamp <= 1'b0;
		end else begin
			tx_prev <= tx_line;
			tx_cnt <= next_tx_cnt;
			ir_tx_out <= next_ir_tx;
			tx_activity_lamp <= tx_low;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive decoder

	logic rx_prev;
	logic stretch;
	logic [TIMER_W-1:0] rx_cnt;
	wire logic rx_gated;
	wire logic rx_rise;
	wire logic stretch_end;
	wire logic rx_out_low;

	// with output one set, echo of our own pulses never reaches the pulse detector
	assign rx_gated = rx_pin && !(echo_suppress && tx_busy);
	assign rx_rise = rx_gated && !rx_prev;
	assign stretch_end = stretch && (rx_cnt >= bit_last);
	// a stretch that began before transmit is cut, not left hanging
	assign rx_out_low = stretch && !(echo_suppress && tx_busy);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_prev <= 1'b0;
			stretch <= 1'b0;
			rx_cnt <= '0;
		end else begin
			rx_prev <= rx_gated;
			if (rx_rise) begin
				stretch <= 1'b1;
				rx_cnt <= '0;
			end else if (stretch_end) begin
				stretch <= 1'b0;
			end else if (stretch) begin
				rx_cnt <= rx_cnt + TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			uart_serial_out <= 1'b1;
			rx_activity_lamp <= 1'b0;
		end else begin
			uart_serial_out <= !rx_out_low;
			// lamp shows what the uart sees, not the raw stretch
			rx_activity_lamp <= rx_out_low;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control character receiver, 8N1 at the current rate

	prog_state_type prog_state;
	logic [TIMER_W-1:0] prog_cnt;
	logic [2:0] prog_bit;
	logic [UART_DATA_BITS-1:0] prog_shift;
	wire logic prog_tick;
	wire logic prog_half;
	wire logic char_done;

	assign prog_tick = (prog_cnt >= bit_last);
	assign prog_half = (prog_cnt >= half_cyc);
	// a character still finishing as select drops is not taken
	assign char_done = prog_mode && (prog_state == PROG_STOP) && prog_tick && tx_line;

	always_ff @(posedge clk) begin
		if (!rst_n || !prog_mode) begin
			prog_state <= PROG_IDLE;
			prog_cnt <= '0;
			prog_bit <= '0;
			prog_shift <= '0;
		end else begin
			unique case (prog_state)
				PROG_IDLE: begin
					prog_cnt <= '0;
					if (tx_fall) begin
						prog_state <= PROG_START;
					end
				end
				PROG_START: begin
					if (tx_line) begin
						prog_state <= PROG_IDLE;
					end else if (prog_half) begin
						prog_cnt <= '0;
						prog_bit <= '0;
						prog_state <= PROG_DATA;
					end else begin
						prog_cnt <= prog_cnt + TIMER_W'(1);
					end
				end
				PROG_DATA: begin
					if (prog_tick) begin
						prog_cnt <= '0;
						prog_shift <= {tx_line, prog_shift[UART_DATA_BITS-1:1]};
						prog_bit <= prog_bit + 3'h1;
						if (prog_bit == LAST_DATA_BIT) begin
							prog_state <= PROG_STOP;
						end
					end else begin
						prog_cnt <= prog_cnt + TIMER_W'(1);
					end
				end
				PROG_STOP: begin
					if (prog_tick) begin
						prog_cnt <= '0;
						prog_state <= PROG_IDLE;
					end else begin
						prog_cnt <= prog_cnt + TIMER_W'(1);
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register port and configuration update

	wire logic cfg_hit;
	wire logic status_hit;
	wire logic rate_ok_bus;
	wire logic rate_ok_char;
	wire logic [CFG_W-1:0] bus_cfg;
	wire logic [CFG_W-1:0] char_cfg;
	wire logic [CFG_W-1:0] status_word;
	wire logic [CFG_W-1:0] read_mux;

	assign cfg_hit = (reg_addr == CFG_ADDR);
	assign status_hit = (reg_addr == STATUS_ADDR);
	assign rate_ok_bus = (reg_wdata[CFG_RATE_MSB:CFG_RATE_LSB] <= RATE_CODE_MAX);
	assign rate_ok_char = (prog_shift[CFG_RATE_MSB:CFG_RATE_LSB] <= RATE_CODE_MAX);
	// undefined rate codes keep the current rate; bit 7 is dropped
	assign bus_cfg = {1'b0, reg_wdata[CFG_OUT2_BIT:CFG_PW_BIT],
		rate_ok_bus ? reg_wdata[CFG_RATE_MSB:CFG_RATE_LSB] : rate_code};
	assign char_cfg = {1'b0, prog_shift[CFG_OUT2_BIT:CFG_PW_BIT],
		rate_ok_char ? prog_shift[CFG_RATE_MSB:CFG_RATE_LSB] : pending[CFG_RATE_MSB:CFG_RATE_LSB]};
	assign status_word[CFG_W-1:STAT_PEND_BIT+1] = '0;
	assign status_word[STAT_PEND_BIT] = pending_valid;
	assign status_word[STAT_RX_BIT] = stretch;
	assign status_word[STAT_TX_BIT] = tx_busy;
	assign status_word[STAT_PROG_BIT] = prog_mode;
	assign read_mux = cfg_hit ? cfg : (status_hit ? status_word : '0);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg <= CFG_RESET;
			pending <= CFG_RESET;
			pending_valid <= 1'b0;
			prog_prev <= 1'b0;
			reg_rdata <= '0;
		end else begin
			prog_prev <= prog_mode;
			if (char_done) begin
				pending <= char_cfg;
				pending_valid <= 1'b1;
			end else if (prog_release) begin
				pending_valid <= 1'b0;
			end else if (prog_mode && !pending_valid) begin
				pending <= cfg;
			end
			// serial settings only once select drops, winning over a bus write in that cycle; a bus write otherwise applies at once
			if (prog_release && pending_valid) begin
				cfg <= pending;
			end else if (reg_write && cfg_hit) begin
				cfg <= bus_cfg;
			end
			reg_rdata <= reg_read ? read_mux : '0;
		end
	end

	assign user_output_one = cfg[CFG_OUT1_BIT];
	assign user_output_two = cfg[CFG_OUT2_BIT];

endmodule // sir_pulse_endec

`default_nettype wire

// ===== sir_pulse_endec_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module sir_pulse_endec_monitor
	import sir_endec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial and transceiver pins
	input wire logic uart_serial_in,
	input wire logic rate_program_select,
	input wire logic uart_serial_out,
	input wire logic ir_tx_out,
	input wire logic ir_rx_in,
	// indicators and outputs
	input wire logic tx_activity_lamp,
	input wire logic rx_activity_lamp,
	input wire logic user_output_one,
	input wire logic user_output_two,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [CFG_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [CFG_W-1:0] reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// long select hold, so no pulse can still be in flight
	logic [10:0] sel_cnt;
	always_ff @(posedge clk) begin
		if (!rst_n || !rate_program_select) sel_cnt <= '0;
		else if (sel_cnt != 11'h7ff) sel_cnt <= sel_cnt + 11'h001;
	end
	// high time of the current pulse, saturating; longest legal pulse is 3/16 at 1200
	logic [10:0] hi_cnt;
	always_ff @(posedge clk) begin
		if (!rst_n || !ir_tx_out) hi_cnt <= '0;
		else if (hi_cnt != 11'h7ff) hi_cnt <= hi_cnt + 11'h001;
	end
	sequence s_tx_fall;
		$fell(uart_serial_in) ##1 (!uart_serial_in && !rate_program_select)[*4];
	endsequence
	sequence s_rx_rise;
		$rose(ir_rx_in) && uart_serial_in && !ir_tx_out
		##1 (ir_rx_in && uart_serial_in && !ir_tx_out && !rate_program_select)[*4];
	endsequence
	a_reset_idle: assert property (disable iff (1'b0)
		!rst_n |=> !ir_tx_out && uart_serial_out && user_output_one && !user_output_two)
		else $error("outputs not idle after reset");
	a_tx_start: assert property (s_tx_fall |=> ir_tx_out && tx_activity_lamp)
		else $error("no pulse for zero bit");
	a_pulse_width: assert property ($rose(ir_tx_out) |->
		ir_tx_out[*8] ##1 ir_tx_out[*8]) else $error("bad pulse width");
	a_pulse_bound: assert property (hi_cnt <= 11'h640)
		else $error("pulse too long");
	a_prog_dark: assert property (sel_cnt == 11'h7ff |-> !ir_tx_out && !tx_activity_lamp)
		else $error("pulse in programming mode");
	a_rx_stretch: assert property (s_rx_rise |-> ##2 !uart_serial_out && rx_activity_lamp)
		else $error("receive pulse not decoded");
	a_echo_gate: assert property (user_output_one && ir_tx_out && $past(ir_tx_out, 2)
		|-> !$fell(uart_serial_out)) else $error("echo reached output");
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
		else $error("read data outside read slot");
	a_unmapped_read: assert property (reg_read && reg_addr != CFG_ADDR
		&& reg_addr != STATUS_ADDR |=> reg_rdata == '0) else $error("unmapped read not zero");
	a_cfg_write: assert property ((!rate_program_select)[*6] ##0
		(reg_write && reg_addr == CFG_ADDR) |=> {user_output_two, user_output_one}
		== $past(reg_wdata[6:5])) else $error("user outputs not updated");
endmodule // sir_pulse_endec_monitor

`default_nettype wire

// ===== sir_far_end.sv
`timescale 1ns/10ps
`default_nettype none

module sir_far_end
	import sir_endec_pkg::*;
(
	// clock
	input wire logic clk,
	// host serial port
	output logic uart_serial_in,
	output logic rate_program_select,
	// echo-on transceiver
	output logic ir_rx_in,
	input wire logic ir_tx_out
);
	logic rx_pulse = 1'b0;
	// echoes its own light: the hard case for the gate
	assign ir_rx_in = rx_pulse | (ir_tx_out === 1'b1);
	initial begin
		uart_serial_in = 1'b1;
		rate_program_select = 1'b0;
	end
	task automatic send_char(input logic [7:0] b, input int bc);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			uart_serial_in <= f[i];
			repeat (bc) @(posedge clk);
		end
	endtask
	task automatic prog_char(input logic [7:0] b, input int bc);
		rate_program_select <= 1'b1;
		repeat (8) @(posedge clk);
		send_char(b, bc);
		rate_program_select <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic pulse(input int w);
		rx_pulse <= 1'b1;
		repeat (w) @(posedge clk);
		rx_pulse <= 1'b0;
	endtask
endmodule // sir_far_end

`default_nettype wire

// ===== tb_sir_pulse_endec.sv
`timescale 1ns/10ps
`default_nettype none

module tb_sir_pulse_endec;
	import sir_endec_pkg::*;
	localparam int CLK = 10000000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic uart_serial_in, rate_program_select, uart_serial_out, ir_tx_out, ir_rx_in;
	logic tx_activity_lamp, rx_activity_lamp, user_output_one, user_output_two;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [CFG_W-1:0] reg_wdata = '0, reg_rdata, rd_val;
	logic reg_write = 1'b0, reg_read = 1'b0, txq = 1'b0, rx_seen = 1'b0;
	logic [8:0] mask = '0;
	logic [31:0] seed = 32'h1e2f;
	logic [7:0] cfgs [4] = '{8'h36, 8'h26, 8'h30, 8'h20};
	int tests_run = 0, miscompares = 0, cyc = 0, t = 0, t0 = 0;
	int bc = 1042, pw = 0, np = 0, lo = 0, lolen = 0;

	always #50 clk = ~clk;
	sir_pulse_endec #(.CLK_HZ(CLK)) sir_pulse_endec_inst (.*);
	sir_far_end sir_far_end_inst (.*);

	////////////////////////////////////////////////////////////////////////////////
	// pulse slots by bit index, pulse width, stretch length
	always @(posedge clk) begin
		t <= t + 1;
		txq <= ir_tx_out;
		if (!uart_serial_out) rx_seen <= 1'b1;
		lo <= uart_serial_out ? 0 : lo + 1;
		if (uart_serial_out && lo != 0) lolen <= lo;
		if (ir_tx_out) pw <= txq ? pw + 1 : 1;
		if (ir_tx_out && !txq) begin
			if (np == 0) t0 <= t;
			mask[np == 0 ? 0 : (t - t0 + bc / 2) / bc] <= 1'b1;
			np <= np + 1;
		end
		cyc <= cyc + 1;
		// about 72.5k cycles of traffic; a hang ends here
		if (cyc == 95000) begin
			miscompares++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	function automatic int bitclk(input logic [3:0] c);
		return int'((CLK + RATE_BPS[c] / 2) / RATE_BPS[c]);
	endfunction
	function automatic int pulse_len(input logic [7:0] c);
		longint b;
		b = RATE_BPS[c[3:0]];
		if (c[CFG_PW_BIT]) return int'((FIXED_PULSE_NS * CLK + NS_PER_S / 2) / NS_PER_S);
		return int'((2 * SHORT_PULSE_NUM * CLK + SHORT_PULSE_DEN * b)
			/ (2 * SHORT_PULSE_DEN * b));
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic tx_check(input logic [7:0] c);
		logic [7:0] b;
		b = rnd();
		bc = bitclk(c[3:0]);
		np <= 0;
		mask <= '0;
		rx_seen <= 1'b0;
		@(posedge clk);
		sir_far_end_inst.send_char(b, bc);
		repeat (bc) @(posedge clk);
		chk("pulse slots", {~b, 1'b1}, mask);
		chk("pulse width", pulse_len(c), pw);
		chk("echo seen", !c[CFG_OUT1_BIT], rx_seen);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(CFG_ADDR, rd_val);
		chk("cfg reset", CFG_RESET, rd_val);
		rd(STATUS_ADDR, rd_val);
		chk("status idle", 8'h00, rd_val);
		rd(4'h8, rd_val);
		chk("unmapped", 0, rd_val);
		wr(CFG_ADDR, 8'hbd);
		rd(CFG_ADDR, rd_val);
		chk("bad rate kept", 8'h36, rd_val);
		np <= 0;
		sir_far_end_inst.prog_char(8'h55, bitclk(4'h6));
		chk("pulses in prog", 0, np);
		rd(CFG_ADDR, rd_val);
		chk("cfg by serial", 8'h55, rd_val);
		chk("user outputs", 2'b10, {user_output_two, user_output_one});
		tx_check(8'h55);
		foreach (cfgs[i]) begin
			wr(CFG_ADDR, cfgs[i]);
			tx_check(cfgs[i]);
		end
		for (int c = 0; c < RATE_COUNT; c++) begin
			wr(CFG_ADDR, 8'h30 | 8'(c));
			bc = bitclk(4'(c));
			sir_far_end_inst.pulse(20 + rnd() % 40);
			repeat (bc + 20) @(posedge clk);
			chk("stretch", bc, lolen);
		end
		conclude();
	end
endmodule // tb_sir_pulse_endec

bind sir_pulse_endec sir_pulse_endec_monitor sir_pulse_endec_monitor_inst (.*);

`default_nettype wire
